// ==== logic/bcf_params.svh ====
`ifndef BCF_PARAMS_SVH
`define BCF_PARAMS_SVH

// Store-alternate space codes that start a block operation (values arbitrary)
`define BCF_ASI_COPY 8'h17
`define BCF_ASI_FILL 8'h1F

// Block geometry
`define BCF_BLOCK_BYTES 32
`define BCF_DWORD_BYTES 8
`define BCF_BEATS 4
`define BCF_OFFSET_BITS 5
`define BCF_BEAT_SHIFT 3

// Reset values
`define BCF_ADDR_RESET 32'h0000_0000
`define BCF_DWORD_RESET 64'h0000_0000_0000_0000

`endif

// ==== logic/bcf_pkg.sv ====
package bcf_pkg;

	typedef logic [31:0] bcf_addr_t;
	typedef logic [63:0] bcf_dword_t;
	typedef logic [7:0] bcf_asi_t;

	// Gray along IDLE -> READ -> MOVE -> WRITE -> IDLE
	typedef enum logic [1:0]
	{
		BCF_IDLE = 2'b00,
		BCF_READ = 2'b01,
		BCF_MOVE = 2'b11,
		BCF_WRITE = 2'b10
	} bcf_state_t;

endpackage

// ==== logic/bcf_block_buf.sv ====
`timescale 1ns/1ps
`include "bcf_params.svh"

// One block of doublewords in flip-flops: single-entry write, whole-block
// load and an indexed read port.
module bcf_block_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = `BCF_BEATS,
	parameter int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Single entry write
	input wire logic wr_en,
	input wire logic [IW-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	// Whole block load
	input wire logic load_all,
	input wire logic [DEPTH*WIDTH-1:0] load_data,
	// Read side
	input wire logic [IW-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data,
	output logic [DEPTH*WIDTH-1:0] all_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Storage; a whole-block load wins over a single write
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_entry
		always_ff @(posedge clk or posedge sys_rst)
		begin
			if (sys_rst)
				mem[i] <= '0;
			else if (load_all)
				mem[i] <= load_data[i*WIDTH +: WIDTH];
			else if (wr_en && (wr_idx == IW'(i)))
				mem[i] <= wr_data;
		end
		assign all_data[i*WIDTH +: WIDTH] = mem[i];
	end

	////////////////////////////////////////////////////////////////////////
	// Read straight from the flops
	assign rd_data = mem[rd_idx];

endmodule

// ==== logic/bcf_engine.sv ====
`timescale 1ns/1ps
`include "bcf_params.svh"

module bcf_engine #(
	parameter int BEATS = `BCF_BEATS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Processor store-alternate requests
	input wire logic st_valid,
	input wire bcf_pkg::bcf_asi_t st_asi,
	input wire bcf_pkg::bcf_addr_t st_addr,
	input wire bcf_pkg::bcf_dword_t st_data,
	output logic st_ready,
	// Ordinary stores passed on unchanged
	output logic fwd_valid,
	output bcf_pkg::bcf_asi_t fwd_asi,
	output bcf_pkg::bcf_addr_t fwd_addr,
	output bcf_pkg::bcf_dword_t fwd_data,
	// Processor hold and status
	output logic cpu_stall,
	output logic busy,
	// System memory bus
	output logic mem_req,
	output logic mem_we,
	output logic mem_nocache,
	output bcf_pkg::bcf_addr_t mem_addr,
	output bcf_pkg::bcf_dword_t mem_wdata,
	input wire logic mem_ack,
	input wire bcf_pkg::bcf_dword_t mem_rdata
);

	import bcf_pkg::*;

	localparam int BW = (BEATS > 1) ? $clog2(BEATS) : 1;
	localparam logic [BW-1:0] LAST_BEAT = BW'(BEATS - 1);

	bcf_state_t state;
	bcf_state_t next_state;
	logic [BW-1:0] beat;
	bcf_addr_t src_base;
	bcf_addr_t dst_base;
	logic is_copy;
	logic is_fill;
	logic is_block;
	logic take_copy;
	logic take_fill;
	logic take_plain;
	logic last_ack;
	logic rd_wr_en;
	logic wb_load;
	logic [BEATS*64-1:0] wb_load_data;
	logic [BEATS*64-1:0] rb_all;
	logic [BEATS*64-1:0] fill_pattern;
	bcf_dword_t wb_rd_data;

	////////////////////////////////////////////////////////////////////////
	// Request decode
	// Only the two block space codes are claimed; everything else stays a
	// normal store so ordinary traffic never waits on a block in flight.
	assign is_copy = (st_asi == `BCF_ASI_COPY);
	assign is_fill = (st_asi == `BCF_ASI_FILL);
	assign is_block = is_copy || is_fill;
	assign st_ready = (state == BCF_IDLE) || !is_block;
	assign take_copy = st_valid && st_ready && is_copy;
	assign take_fill = st_valid && st_ready && is_fill;
	assign take_plain = st_valid && !is_block;
	assign last_ack = mem_ack && (beat == LAST_BEAT);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			BCF_IDLE:
			begin
				if (take_copy)
					next_state = BCF_READ;
				else if (take_fill)
					next_state = BCF_WRITE;
			end
			BCF_READ:
			begin
				if (last_ack)
					next_state = BCF_MOVE;
			end
			BCF_MOVE:
				next_state = BCF_WRITE;
			BCF_WRITE:
			begin
				if (last_ack)
					next_state = BCF_IDLE;
			end
			default:
				next_state = BCF_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= BCF_IDLE;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// Beat counter: one doubleword per acknowledge, restarts per phase
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			beat <= '0;
		else if (state != next_state)
			beat <= '0;
		else if (mem_ack && ((state == BCF_READ) || (state == BCF_WRITE)))
			beat <= beat + BW'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// Block base addresses
	// Copy: st_addr is the destination, st_data[31:0] the source.
	// Fill: st_addr is the destination. Low offset bits are dropped so a
	// misaligned address can never straddle two blocks.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			src_base <= `BCF_ADDR_RESET;
			dst_base <= `BCF_ADDR_RESET;
		end
		else if (take_copy || take_fill)
		begin
			src_base <= {st_data[31:`BCF_OFFSET_BITS],
				`BCF_OFFSET_BITS'(0)};
			dst_base <= {st_addr[31:`BCF_OFFSET_BITS],
				`BCF_OFFSET_BITS'(0)};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read and write buffers
	assign rd_wr_en = (state == BCF_READ) && mem_ack;
	assign fill_pattern = {BEATS{st_data}};
	assign wb_load = take_fill || (state == BCF_MOVE);
	assign wb_load_data = take_fill ? fill_pattern : rb_all;

	bcf_block_buf #(
		.WIDTH(64),
		.DEPTH(BEATS)
	) u_read_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(rd_wr_en),
		.wr_idx(beat),
		.wr_data(mem_rdata),
		.load_all(1'b0),
		.load_data({BEATS*64{1'b0}}),
		.rd_idx(beat),
		.rd_data(),
		.all_data(rb_all)
	);

	bcf_block_buf #(
		.WIDTH(64),
		.DEPTH(BEATS)
	) u_write_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(1'b0),
		.wr_idx(beat),
		.wr_data(`BCF_DWORD_RESET),
		.load_all(wb_load),
		.load_data(wb_load_data),
		.rd_idx(beat),
		.rd_data(wb_rd_data),
		.all_data()
	);

	////////////////////////////////////////////////////////////////////////
	// Memory bus side
	// Every block beat is marked non-allocating so neither the copied nor
	// the filled data displaces lines in the cache.
	assign mem_req = (state == BCF_READ) || (state == BCF_WRITE);
	assign mem_we = (state == BCF_WRITE);
	assign mem_nocache = mem_req;
	// Beat offset is sized to the bus so any BEATS value keeps widths exact
	assign mem_addr = ((state == BCF_READ) ? src_base : dst_base)
		| bcf_addr_t'({beat, 3'h0});
	assign mem_wdata = wb_rd_data;

	////////////////////////////////////////////////////////////////////////
	// Processor hold
	// Held only until the source sits in the write buffer; the write back
	// overlaps with execution, which is the point of the feature.
	assign cpu_stall = (state == BCF_READ) || (state == BCF_MOVE);
	assign busy = (state != BCF_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Ordinary store pass-through, registered one cycle
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fwd_valid <= 1'b0;
			fwd_asi <= '0;
			fwd_addr <= `BCF_ADDR_RESET;
			fwd_data <= `BCF_DWORD_RESET;
		end
		else
		begin
			fwd_valid <= take_plain;
			if (take_plain)
			begin
				fwd_asi <= st_asi;
				fwd_addr <= st_addr;
				fwd_data <= st_data;
			end
		end
	end

endmodule

// ==== tb/bcf_engine_asserts.sv ====
`timescale 1ns/1ps
`include "bcf_params.svh"
module bcf_engine_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Watched ports
	input wire logic st_valid,
	input wire bcf_pkg::bcf_asi_t st_asi,
	input wire logic st_ready,
	input wire logic fwd_valid,
	input wire logic cpu_stall,
	input wire logic busy,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_nocache,
	input wire bcf_pkg::bcf_addr_t mem_addr,
	input wire logic mem_ack
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////
	// Steps of a block operation, and plain store pass-through
	sequence s_take(c);
		st_valid && st_ready && st_asi == c;
	endsequence
	sequence s_rd_end;
		mem_req && !mem_we && mem_ack && mem_addr[4:3] == 2'h3;
	endsequence
	property p_copy;
		s_take(`BCF_ASI_COPY) |=> mem_req && !mem_we && cpu_stall;
	endproperty
	a_copy: assert property (p_copy) else $error("copy start");
	property p_fill;
		s_take(`BCF_ASI_FILL) |=> mem_req && mem_we && !cpu_stall;
	endproperty
	a_fill: assert property (p_fill) else $error("fill start");
	property p_move;
		s_rd_end |=> !mem_req && cpu_stall ##1 mem_we && !cpu_stall;
	endproperty
	a_move: assert property (p_move) else $error("move step");
	property p_beat;
		mem_req && mem_ack && mem_addr[4:3] != 2'h3 |=>
			mem_req && mem_addr[4:3] == $past(mem_addr[4:3]) + 2'h1;
	endproperty
	a_beat: assert property (p_beat) else $error("beat order");
	property p_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("beat hold");
	property p_nocache;
		mem_req |-> mem_nocache && busy;
	endproperty
	a_nocache: assert property (p_nocache) else $error("cached");
	property p_stall;
		mem_req |-> cpu_stall == !mem_we && mem_addr[2:0] == 3'h0;
	endproperty
	a_stall: assert property (p_stall) else $error("stall");
	property p_fwd;
		st_valid && st_asi != `BCF_ASI_COPY && st_asi != `BCF_ASI_FILL
			|-> st_ready ##1 fwd_valid;
	endproperty
	a_fwd: assert property (p_fwd) else $error("plain store");
endmodule
bind bcf_engine bcf_engine_asserts chk_u (
	.clk(clk),
	.sys_rst(sys_rst),
	.st_valid(st_valid),
	.st_asi(st_asi),
	.st_ready(st_ready),
	.fwd_valid(fwd_valid),
	.cpu_stall(cpu_stall),
	.busy(busy),
	.mem_req(mem_req),
	.mem_we(mem_we),
	.mem_nocache(mem_nocache),
	.mem_addr(mem_addr),
	.mem_ack(mem_ack)
);

// ==== tb/bcf_mem_model.sv ====
`timescale 1ns/1ps
// Main memory; in slow mode a beat is acked only every other slot
module bcf_mem_model (
	// Clock and bus
	input wire logic clk,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire bcf_pkg::bcf_addr_t mem_addr,
	input wire bcf_pkg::bcf_dword_t mem_wdata,
	output logic mem_ack,
	output bcf_pkg::bcf_dword_t mem_rdata
);
	bcf_pkg::bcf_dword_t mem [0:127];
	logic tick = 1'b0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 64'h0000_0000_0000_0000;
	// Idle read data flips so a stale sample cannot pass
	always @(posedge clk)
	begin
		tick <= ~tick;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack && (!slow || tick))
		begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr[9:3]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[9:3]];
		end
	end
endmodule

// ==== tb/test_bcf_engine.sv ====
`timescale 1ns/1ps
`include "bcf_params.svh"
module test_bcf_engine;
	import bcf_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slow = 1'b0;
	logic st_valid = 1'b0;
	bcf_asi_t st_asi = 8'h00;
	bcf_addr_t st_addr = 32'h0000_0000;
	bcf_dword_t st_data = 64'h0000_0000_0000_0000;
	logic st_ready, fwd_valid, cpu_stall, busy, mem_req, mem_we, mem_ack;
	bcf_asi_t fwd_asi;
	bcf_addr_t fwd_addr, mem_addr;
	bcf_dword_t fwd_data, mem_wdata, mem_rdata;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int reads = 0;
	always #50 clk = ~clk;
	bcf_engine dut_u (.*, .mem_nocache());
	bcf_mem_model mem_u (.*);
	////////////////////
	// Cycle ceiling and a count of read beats
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (mem_req && !mem_we && mem_ack)
			reads <= reads + 1;
		if (cyc == 3000)
		begin
			num_errors++;
			print_verdict;
		end
	end
	task print_verdict;
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Opens on a falling edge, so a new request never meets the drop of
	// the last one in the same step; st_ready is read once settled, and
	// the rising edge after a high read is the one that takes it.
	task issue(input bcf_asi_t a, input bcf_addr_t ad, input bcf_dword_t d);
		logic took;
		@(negedge clk);
		st_asi = a;
		st_addr = ad;
		st_data = d;
		st_valid = 1'b1;
		took = 1'b0;
		while (!took)
		begin
			#1;
			took = (st_ready === 1'b1);
			@(posedge clk);
		end
		@(negedge clk);
		st_valid = 1'b0;
	endtask
	task wait_idle;
		repeat (200)
		begin
			@(negedge clk);
			if (busy === 1'b0)
				break;
		end
		chk("idle", busy, 1'b0);
	endtask
	task t_plain(input bcf_addr_t ad, input bcf_dword_t d);
		issue(8'h0A, ad, d);
		chk("fwd valid", fwd_valid, 1'b1);
		chk("fwd asi", fwd_asi, 8'h0A);
		chk("fwd addr", fwd_addr, ad);
		chk("fwd data", fwd_data, d);
	endtask
	task t_copy(input bcf_addr_t src, input bcf_addr_t dst, input logic s);
		int r0;
		slow = s;
		r0 = reads;
		for (int i = 0; i < 4; i++)
			mem_u.mem[src[9:3] + i] = 64'hA5A5_0000_0000_0000 + src + i;
		// Unaligned low bits must be dropped
		issue(`BCF_ASI_COPY, dst | 32'h0000_0005,
			{32'h0000_0000, src | 32'h0000_0007});
		chk("ready stall", {st_ready, cpu_stall}, 2'b01);
		wait_idle;
		chk("copy reads", reads - r0, `BCF_BEATS);
		for (int i = 0; i < 4; i++)
			chk("copy", mem_u.mem[dst[9:3] + i],
				64'hA5A5_0000_0000_0000 + src + i);
	endtask
	task t_fill(input bcf_addr_t dst, input bcf_dword_t pat);
		int r0;
		r0 = reads;
		issue(`BCF_ASI_FILL, dst, pat);
		chk("fill stall", cpu_stall, 1'b0);
		chk("fill refused", st_ready, 1'b0);
		// Ordinary stores still pass while the block is written back
		t_plain(32'h0000_0108, 64'h0000_0000_0000_0055);
		chk("fill busy", busy, 1'b1);
		wait_idle;
		chk("fill reads", reads - r0, 0);
		for (int i = 0; i < 4; i++)
			chk("fill", mem_u.mem[dst[9:3] + i], pat);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		t_plain(32'h0000_0104, 64'h0000_0000_0000_00FF);
		t_copy(32'h0000_0040, 32'h0000_0080, 1'b0);
		t_copy(32'h0000_0100, 32'h0000_0200, 1'b1);
		t_fill(32'h0000_0300, 64'h1234_5678_9ABC_DEF0);
		print_verdict;
	end
endmodule
